/* File: rtl/liucfg_regs.sv */
`timescale 1ns/1ns
`default_nettype none

module liucfg_regs
    import liucfg_pkg::*;
#(
    parameter int CHANNELS = LIUCFG_CHANNELS,
    parameter int LOS_ZEROS = LIUCFG_LOS_ZEROS_TYP
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic host_cs_n,
    input wire logic host_rd_n,
    input wire logic host_wr_n,
    input wire logic [7:0] host_addr,
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe,
    output logic host_rdy_n,
    input wire logic line_is_e1,
    input wire logic [CHANNELS-1:0] rx_bit_stb,
    input wire logic [CHANNELS-1:0] rx_bit_val,
    output logic [3:0] cable_gauge_sel,
    output logic slice_lower,
    output logic slice_raise,
    output logic eq_cut_1db,
    output logic eq_cut_3db,
    output logic [CHANNELS-1:0] tx_custom_pulse,
    output logic [CHANNELS-1:0] tx_std_pulse,
    output logic [CHANNELS*8-1:0] pulse_reg_base,
    output logic [CHANNELS-1:0] rx_signal_lost
);

    // ****************************************************************
    // Host pin synchronisers
    // ****************************************************************
    logic [2:0] strb_meta_r;
    logic [2:0] strb_sync_r;
    logic cs_act;
    logic rd_act;
    logic wr_act;

    // Strobes come from the host's own timing, so they cross two flops first.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strb_meta_r <= 3'h7;
            strb_sync_r <= 3'h7;
        end else begin
            strb_meta_r <= {host_cs_n, host_rd_n, host_wr_n};
            strb_sync_r <= strb_meta_r;
        end
    end

    assign cs_act = ~strb_sync_r[2];
    assign rd_act = ~strb_sync_r[1];
    assign wr_act = ~strb_sync_r[0];

    // ****************************************************************
    // Host access sequencer
    // ****************************************************************
    liucfg_state_t state_r;
    logic [7:0] addr_r;
    logic [7:0] wdata_r;
    logic wr_commit;

    // Address and data are stable long before the synchronised strobe arrives,
    // so they are sampled directly; a short strobe that spans no clock edge is missed.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= LIUCFG_ST_IDLE;
            addr_r <= 8'h00;
            wdata_r <= 8'h00;
        end else begin
            case (state_r)
                LIUCFG_ST_IDLE: begin
                    addr_r <= host_addr;
                    wdata_r <= host_data_in;
                    if (cs_act && rd_act) begin
                        state_r <= LIUCFG_ST_READ;
                    end else if (cs_act && wr_act) begin
                        state_r <= LIUCFG_ST_WRITE;
                    end
                end
                LIUCFG_ST_READ: begin
                    if (!(cs_act && rd_act)) begin
                        state_r <= LIUCFG_ST_IDLE;
                    end
                end
                LIUCFG_ST_WRITE: begin
                    wdata_r <= host_data_in;
                    if (!(cs_act && wr_act)) begin
                        state_r <= LIUCFG_ST_IDLE;
                    end
                end
                default: begin
                    state_r <= LIUCFG_ST_IDLE;
                end
            endcase
        end
    end

    // The write lands when the host lets go of its strobe.
    // Waiting for the release lets the host settle its data late in the strobe,
    // at the cost of two extra cycles per write.
    assign wr_commit = (state_r == LIUCFG_ST_WRITE) && !(cs_act && wr_act);

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0] line_tuning_r;
    logic [7:0] arb_pulse_ctrl_r;

    // All eight bits of both bytes are stored, reserved ones included.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            line_tuning_r <= LIUCFG_LINE_TUNING_RST;
            arb_pulse_ctrl_r <= LIUCFG_ARB_PULSE_CTRL_RST;
        end else if (wr_commit) begin
            if (addr_r == LIUCFG_ADDR_LINE_TUNING) begin
                line_tuning_r <= wdata_r;
            end else if (addr_r == LIUCFG_ADDR_ARB_PULSE_CTRL) begin
                arb_pulse_ctrl_r <= wdata_r;
            end
        end
    end

    // Read data, bus drive and ready; unmapped addresses read as zero.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            host_data_out <= 8'h00;
            host_data_oe <= 1'b0;
            host_rdy_n <= 1'b1;
        end else begin
            host_data_oe <= (state_r == LIUCFG_ST_READ) && cs_act && rd_act;
            host_rdy_n <= (state_r == LIUCFG_ST_IDLE) || wr_commit || !(cs_act && (rd_act || wr_act));
            if (addr_r == LIUCFG_ADDR_LINE_TUNING) begin
                host_data_out <= line_tuning_r;
            end else if (addr_r == LIUCFG_ADDR_ARB_PULSE_CTRL) begin
                host_data_out <= arb_pulse_ctrl_r;
            end else begin
                host_data_out <= LIUCFG_UNMAPPED_READ;
            end
        end
    end

    // ****************************************************************
    // Field decoder
    // ****************************************************************
    liucfg_cfg_if cfg_bus ();

    assign cfg_bus.line_tuning = line_tuning_r;
    assign cfg_bus.arb_pulse_ctrl = arb_pulse_ctrl_r;
    assign cfg_bus.line_is_e1 = line_is_e1;

    // Receive selects stay static between writes, pulse selects also follow line_is_e1; all follow one edge after the register.
    liucfg_decode #(.CHANNELS(CHANNELS)) u_decode (
        .clk(clk),
        .rst(rst),
        .cfg(cfg_bus),
        .gauge_onehot_r(cable_gauge_sel),
        .slice_lower_r(slice_lower),
        .slice_raise_r(slice_raise),
        .eq_cut_1db_r(eq_cut_1db),
        .eq_cut_3db_r(eq_cut_3db),
        .custom_pulse_r(tx_custom_pulse),
        .std_pulse_r(tx_std_pulse)
    );

    // Each channel's shape registers start at offset n8; the channel logic reads n8 through nF.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pulse_reg_base <= '0;
        end else begin
            for (int ch = 0; ch < CHANNELS; ch++) begin
                pulse_reg_base[ch*8 +: 8] <= {ch[3:0], LIUCFG_PULSE_REG_FIRST};
            end
        end
    end

    // ****************************************************************
    // T1 loss-of-signal zero counters
    // ****************************************************************
    localparam logic [LIUCFG_LOS_CNT_W-1:0] LOS_LIMIT = LIUCFG_LOS_CNT_W'(LOS_ZEROS);
    logic [LIUCFG_LOS_CNT_W-1:0] zero_cnt_r [CHANNELS];

    // A one ends the run; the counter saturates at the limit so it cannot wrap and clear loss.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int ch = 0; ch < CHANNELS; ch++) begin
                zero_cnt_r[ch] <= '0;
            end
            rx_signal_lost <= '0;
        end else begin
            for (int ch = 0; ch < CHANNELS; ch++) begin
                if (line_is_e1) begin
                    zero_cnt_r[ch] <= '0;
                    rx_signal_lost[ch] <= 1'b0;
                end else if (rx_bit_stb[ch]) begin
                    if (rx_bit_val[ch]) begin
                        zero_cnt_r[ch] <= '0;
                        rx_signal_lost[ch] <= 1'b0;
                    end else if (zero_cnt_r[ch] < LOS_LIMIT) begin
                        zero_cnt_r[ch] <= zero_cnt_r[ch] + 1'b1;
                        rx_signal_lost[ch] <= (zero_cnt_r[ch] + 1'b1 == LOS_LIMIT);
                    end
                end
            end
        end
    end

endmodule

`default_nettype wire

/* File: rtl/liucfg_pkg.sv */
package liucfg_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] LIUCFG_ADDR_LINE_TUNING = 8'h80;
    localparam logic [7:0] LIUCFG_ADDR_ARB_PULSE_CTRL = 8'hC0;
    localparam logic [7:0] LIUCFG_LINE_TUNING_RST = 8'h00;
    localparam logic [7:0] LIUCFG_ARB_PULSE_CTRL_RST = 8'h00;
    localparam logic [7:0] LIUCFG_UNMAPPED_READ = 8'h00;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int LIUCFG_CABLE_SIZE_SEL_HI = 7;
    localparam int LIUCFG_CABLE_SIZE_SEL_LO = 6;
    localparam int LIUCFG_SLICE_THRESHOLD_HI = 3;
    localparam int LIUCFG_SLICE_THRESHOLD_LO = 2;
    localparam int LIUCFG_EQ_GAIN_CUT_HI = 1;
    localparam int LIUCFG_EQ_GAIN_CUT_LO = 0;
    localparam int LIUCFG_E1_CUSTOM_PULSE_EN = 0;

    // ****************************************************************
    // Field encodings
    // ****************************************************************
    localparam logic [1:0] LIUCFG_GAUGE_MIXED = 2'h0;
    localparam logic [1:0] LIUCFG_GAUGE_22 = 2'h1;
    localparam logic [1:0] LIUCFG_GAUGE_24 = 2'h2;
    localparam logic [1:0] LIUCFG_GAUGE_26 = 2'h3;
    localparam logic [1:0] LIUCFG_SLICE_LOWER = 2'h1;
    localparam logic [1:0] LIUCFG_SLICE_RAISE = 2'h2;
    localparam logic [1:0] LIUCFG_EQ_CUT_1DB = 2'h1;
    localparam logic [1:0] LIUCFG_EQ_CUT_3DB = 2'h2;

    // ****************************************************************
    // Channels and loss-of-signal counting
    // ****************************************************************
    localparam int LIUCFG_CHANNELS = 8;
    localparam int LIUCFG_LOS_ZEROS_MIN = 100;
    localparam int LIUCFG_LOS_ZEROS_TYP = 175;
    localparam int LIUCFG_LOS_ZEROS_MAX = 250;
    localparam int LIUCFG_LOS_CNT_W = 8;
    localparam logic [3:0] LIUCFG_PULSE_REG_FIRST = 4'h8;

    // ****************************************************************
    // Host port states
    // ****************************************************************
    typedef enum logic [2:0] {
        LIUCFG_ST_IDLE = 3'b001,
        LIUCFG_ST_READ = 3'b010,
        LIUCFG_ST_WRITE = 3'b100
    } liucfg_state_t;

endpackage

/* File: rtl/liucfg_cfg_if.sv */
`timescale 1ns/1ns
`default_nettype none

// Raw register contents travel from the host port to the decoder.
interface liucfg_cfg_if;
    logic [7:0] line_tuning;
    logic [7:0] arb_pulse_ctrl;
    logic line_is_e1;

    modport regs (output line_tuning, output arb_pulse_ctrl, output line_is_e1);
    modport dec (input line_tuning, input arb_pulse_ctrl, input line_is_e1);
endinterface

`default_nettype wire

/* File: rtl/liucfg_decode.sv */
`timescale 1ns/1ns
`default_nettype none

module liucfg_decode
    import liucfg_pkg::*;
#(
    parameter int CHANNELS = LIUCFG_CHANNELS
) (
    input wire logic clk,
    input wire logic rst,
    liucfg_cfg_if.dec cfg,
    output logic [3:0] gauge_onehot_r,
    output logic slice_lower_r,
    output logic slice_raise_r,
    output logic eq_cut_1db_r,
    output logic eq_cut_3db_r,
    output logic [CHANNELS-1:0] custom_pulse_r,
    output logic [CHANNELS-1:0] std_pulse_r
);

    // Turns a two-bit field into a one-hot select.
    function automatic logic [3:0] onehot2(input logic [1:0] code);
        onehot2 = 4'h1 << code;
    endfunction

    logic [1:0] gauge_code;
    logic [1:0] slice_code;
    logic [1:0] eq_code;
    logic custom_on;

    // Field extraction from the raw bytes.
    assign gauge_code = {cfg.line_tuning[LIUCFG_CABLE_SIZE_SEL_HI], cfg.line_tuning[LIUCFG_CABLE_SIZE_SEL_LO]};
    assign slice_code = {cfg.line_tuning[LIUCFG_SLICE_THRESHOLD_HI], cfg.line_tuning[LIUCFG_SLICE_THRESHOLD_LO]};
    assign eq_code = {cfg.line_tuning[LIUCFG_EQ_GAIN_CUT_HI], cfg.line_tuning[LIUCFG_EQ_GAIN_CUT_LO]};
    assign custom_on = cfg.arb_pulse_ctrl[LIUCFG_E1_CUSTOM_PULSE_EN] & cfg.line_is_e1;

    // Receive path selects; codes 00 and 11 both leave slicer and gain at normal.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gauge_onehot_r <= 4'h1;
            slice_lower_r <= 1'b0;
            slice_raise_r <= 1'b0;
            eq_cut_1db_r <= 1'b0;
            eq_cut_3db_r <= 1'b0;
        end else begin
            gauge_onehot_r <= onehot2(gauge_code);
            slice_lower_r <= (slice_code == LIUCFG_SLICE_LOWER);
            slice_raise_r <= (slice_code == LIUCFG_SLICE_RAISE);
            eq_cut_1db_r <= (eq_code == LIUCFG_EQ_CUT_1DB);
            eq_cut_3db_r <= (eq_code == LIUCFG_EQ_CUT_3DB);
        end
    end

    // Transmit pulse source, the same for all channels; only bit 0 of the control byte counts.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            custom_pulse_r <= '0;
            std_pulse_r <= '1;
        end else begin
            custom_pulse_r <= {CHANNELS{custom_on}};
            std_pulse_r <= {CHANNELS{~custom_on}};
        end
    end

endmodule

`default_nettype wire

/* File: dv/liucfg_regs_chk.sv */
`timescale 1ns/1ns
`default_nettype none
// ********
// Port checker
// ********
module liucfg_regs_chk
    import liucfg_pkg::*;
#(
    parameter int CHANNELS = LIUCFG_CHANNELS,
    parameter int LOS_ZEROS = LIUCFG_LOS_ZEROS_TYP
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic host_rdy_n,
    input wire logic line_is_e1,
    input wire logic [CHANNELS-1:0] rx_bit_stb,
    input wire logic [CHANNELS-1:0] rx_bit_val,
    input wire logic [3:0] cable_gauge_sel,
    input wire logic slice_lower,
    input wire logic slice_raise,
    input wire logic eq_cut_1db,
    input wire logic eq_cut_3db,
    input wire logic [CHANNELS-1:0] tx_custom_pulse,
    input wire logic [CHANNELS-1:0] tx_std_pulse,
    input wire logic [CHANNELS*8-1:0] pulse_reg_base,
    input wire logic [CHANNELS-1:0] rx_signal_lost
);
    logic [LIUCFG_LOS_CNT_W-1:0] zero_run_r;
    logic seen_edge_r;
    logic [CHANNELS*8-1:0] base_exp;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Expected shape-register offsets, one byte per channel.
    always_comb begin
        for (int ch = 0; ch < CHANNELS; ch++) begin
            base_exp[ch*8 +: 8] = {4'(ch), LIUCFG_PULSE_REG_FIRST};
        end
    end

    // The offsets appear only after the first edge out of reset.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seen_edge_r <= 1'b0;
        end else begin
            seen_edge_r <= 1'b1;
        end
    end

    // Reference run of zeros on channel 0, saturating like the receiver.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            zero_run_r <= '0;
        end else if (line_is_e1) begin
            zero_run_r <= '0;
        end else if (rx_bit_stb[0]) begin
            if (rx_bit_val[0]) begin
                zero_run_r <= '0;
            end else if (zero_run_r != LIUCFG_LOS_CNT_W'(LOS_ZEROS)) begin
                zero_run_r <= zero_run_r + 1'b1;
            end
        end
    end

    a_gauge_onehot: assert property ($onehot(cable_gauge_sel)) else $error("gauge select not one-hot");
    a_slice_excl: assert property (!(slice_lower && slice_raise)) else $error("slicer both ways");
    a_eq_excl: assert property (!(eq_cut_1db && eq_cut_3db)) else $error("two gain cuts");
    a_std_inverse: assert property (tx_std_pulse == ~tx_custom_pulse) else $error("pulse paths clash");
    a_t1_no_custom: assert property (!line_is_e1 |=> tx_custom_pulse == '0) else $error("custom pulse in T1");
    a_pulse_base: assert property (seen_edge_r |-> pulse_reg_base == base_exp) else $error("shape base wrong");
    a_lost_e1_idle: assert property (line_is_e1 |=> rx_signal_lost == '0) else $error("loss in E1");
    a_los_run_count: assert property (rx_signal_lost[0] == (zero_run_r == LIUCFG_LOS_CNT_W'(LOS_ZEROS)))
        else $error("loss not tied to zero run");
    a_static_cfg: assert property (!$stable({cable_gauge_sel, slice_lower, slice_raise, eq_cut_1db, eq_cut_3db})
        |-> $past(host_rdy_n, 2) == 1'b0) else $error("config moved without a write");
endmodule

bind liucfg_regs liucfg_regs_chk #(.CHANNELS(CHANNELS), .LOS_ZEROS(LOS_ZEROS)) u_chk (.clk(clk), .rst(rst),
    .host_rdy_n(host_rdy_n), .line_is_e1(line_is_e1), .rx_bit_stb(rx_bit_stb), .rx_bit_val(rx_bit_val),
    .cable_gauge_sel(cable_gauge_sel), .slice_lower(slice_lower), .slice_raise(slice_raise),
    .eq_cut_1db(eq_cut_1db), .eq_cut_3db(eq_cut_3db), .tx_custom_pulse(tx_custom_pulse),
    .tx_std_pulse(tx_std_pulse), .pulse_reg_base(pulse_reg_base), .rx_signal_lost(rx_signal_lost));
`default_nettype wire

/* File: dv/liucfg_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ********
// Host processor model
// ********
module liucfg_host_model (
    input wire logic clk,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic [7:0] addr,
    output logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    input wire logic rdy_n
);
    // The port starts deselected.
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        addr = 8'h00;
        data_in = 8'h00;
    end

    // Data is held until the port is idle, since the write commits only after the synced release.
    task automatic xfer(input bit wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
                        output bit tmo);
        int n;
        @(posedge clk);
        #1;
        addr = a;
        data_in = d;
        cs_n = 1'b0;
        wr_n = !wr;
        rd_n = wr;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (rdy_n !== 1'b0 && n < 20);
        q = (wr || data_oe === 1'b1) ? data_out : 8'hXX;
        tmo = (n >= 20);
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        n = 0;
        while (rdy_n !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        tmo = tmo | (n >= 20);
        // Released lines show the inverse so that stale values cannot pass.
        addr = ~a;
        data_in = ~d;
    endtask
endmodule
`default_nettype wire

/* File: dv/liucfg_tb.sv */
`timescale 1ns/1ns
`default_nettype none
// ********
// Testbench
// ********
module tb;
    import liucfg_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cs_n, rd_n, wr_n, oe, rdy_n, sl, sr, e1db, e3db;
    logic e1 = 1'b0;
    logic [7:0] addr, din, dout, cust, std, lost;
    logic [7:0] stb = 8'h00;
    logic [7:0] val = 8'h00;
    logic [3:0] gauge;
    logic [63:0] base, base_e;
    logic [7:0] v;
    int err_count = 0;
    int n_checks = 0;

    // A short loss threshold keeps the zero runs brief.
    liucfg_regs #(.LOS_ZEROS(5)) uut (.clk(clk), .rst(rst), .host_cs_n(cs_n), .host_rd_n(rd_n),
        .host_wr_n(wr_n), .host_addr(addr), .host_data_in(din), .host_data_out(dout), .host_data_oe(oe),
        .host_rdy_n(rdy_n), .line_is_e1(e1), .rx_bit_stb(stb), .rx_bit_val(val), .cable_gauge_sel(gauge),
        .slice_lower(sl), .slice_raise(sr), .eq_cut_1db(e1db), .eq_cut_3db(e3db), .tx_custom_pulse(cust),
        .tx_std_pulse(std), .pulse_reg_base(base), .rx_signal_lost(lost));
    liucfg_host_model host (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(din),
        .data_out(dout), .data_oe(oe), .rdy_n(rdy_n));

    // 25 MHz clock.
    initial begin
        forever #20 clk = ~clk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // A hung access counts once and closes the run.
    task automatic acc(input bit w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        bit t;
        host.xfer(w, a, d, q, t);
        if (t) begin
            chk(64'(t), 64'h0);
            print_verdict();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        acc(1'b1, a, d, q);
        // Decoded outputs follow the stored byte one edge after the write lands.
        @(posedge clk);
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        acc(1'b0, a, 8'h00, q);
        chk(64'(q), 64'(exp));
    endtask

    // Each strobe carries one received bit on every channel in the mask.
    task automatic bits(input logic [7:0] mask, input logic b, input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
            stb = mask;
            val = {8{b}};
            @(posedge clk);
            #1;
            stb = 8'h00;
            val = {8{!b}};
        end
    endtask

    initial begin
        for (int ch = 0; ch < 8; ch++) base_e[ch*8 +: 8] = {4'(ch), LIUCFG_PULSE_REG_FIRST};
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        chk({gauge, sl, sr, e1db, e3db, cust, std}, 24'h1000FF);
        rd(LIUCFG_ADDR_LINE_TUNING, LIUCFG_LINE_TUNING_RST);
        rd(LIUCFG_ADDR_ARB_PULSE_CTRL, LIUCFG_ARB_PULSE_CTRL_RST);
        chk(base, base_e);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            v = {4{2'(i)}};
            wr(LIUCFG_ADDR_LINE_TUNING, v);
            chk({gauge, sl, sr, e1db, e3db}, {4'(1 << i), i == 1, i == 2, i == 1, i == 2});
            rd(LIUCFG_ADDR_LINE_TUNING, v);
        end
        $display("test fields done");
        e1 = 1'b1;
        wr(LIUCFG_ADDR_ARB_PULSE_CTRL, 8'hFE);
        chk({cust, std}, 16'h00FF);
        rd(LIUCFG_ADDR_ARB_PULSE_CTRL, 8'hFE);
        wr(LIUCFG_ADDR_ARB_PULSE_CTRL, 8'h01);
        chk({cust, std}, 16'hFF00);
        e1 = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk({cust, std}, 16'h00FF);
        e1 = 1'b1;
        wr(LIUCFG_ADDR_ARB_PULSE_CTRL, 8'h00);
        chk({cust, std}, 16'h00FF);
        $display("test pulse done");
        wr(8'h81, 8'h55);
        rd(8'h81, LIUCFG_UNMAPPED_READ);
        rd(LIUCFG_ADDR_LINE_TUNING, 8'hFF);
        $display("test unmapped done");
        bits(8'h09, 1'b0, 6);
        chk(lost, 8'h00);
        e1 = 1'b0;
        bits(8'h09, 1'b0, 4);
        chk(lost, 8'h00);
        bits(8'h09, 1'b0, 1);
        chk(lost, 8'h09);
        bits(8'h01, 1'b1, 1);
        chk(lost, 8'h08);
        $display("test loss done");
        @(posedge clk);
        #1;
        rst = 1'b1;
        @(posedge clk);
        #1;
        rst = 1'b0;
        rd(LIUCFG_ADDR_LINE_TUNING, 8'h00);
        chk({gauge, lost}, 12'h100);
        $display("test rereset done");
        print_verdict();
    end
endmodule
`default_nettype wire
